// file: ccdr_top.v
// Purpose: Processor control and diagnostic register bank.
// Assumes: CPU and host port access strobes are one-cycle, same clock.
// Notes: Read data is registered and valid one cycle after the strobe.
`timescale 1ns/100ps
`include "ccdr_consts.vh"
module ccdr_top #(
  parameter WD_CYC0 = `CCDR_WD_CYC(`CCDR_WD_T0_US),
  parameter WD_CYC1 = `CCDR_WD_CYC(`CCDR_WD_T1_US),
  parameter WD_CYC2 = `CCDR_WD_CYC(`CCDR_WD_T2_US),
  parameter WD_CYC3 = `CCDR_WD_CYC(`CCDR_WD_T3_US),
  parameter TOGGLE_DIV = `CCDR_TOGGLE_DIV,
  parameter NSRC = 9
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [15:0] cpu_addr_i,
  input wire cpu_wr_i,
  input wire cpu_rd_i,
  input wire [15:0] cpu_wdata_i,
  output reg [15:0] cpu_rdata_o,
  input wire [15:0] host_addr_i,
  input wire host_wr_i,
  input wire host_rd_i,
  input wire [15:0] host_wdata_i,
  output reg [15:0] host_rdata_o,
  input wire [NSRC-1:0] src_evt_i,
  input wire [NSRC-1:0] src_ack_i,
  output wire [NSRC-1:0] cpu_irq_o,
  input wire [15:0] pc_i,
  output reg breakpoint_irq_o,
  output reg watchdog_irq_o,
  output reg watchdog_cpu_reset_o,
  output wire [15:0] watchdog_status_o,
  output reg first_usb_port_dp_o,
  output reg first_usb_port_dm_o,
  output reg first_usb_port_oe_o,
  output reg first_usb_port_pd_o,
  output reg first_usb_port_lspu_o,
  output reg first_usb_port_fspu_o,
  output reg second_usb_port_dp_o,
  output reg second_usb_port_dm_o,
  output reg second_usb_port_oe_o,
  output reg second_usb_port_pd_o,
  output reg second_usb_port_lspu_o,
  output reg second_usb_port_fspu_o
);

  // --------------------------------------------------------------------------
  // Source order and enable mapping
  // --------------------------------------------------------------------------
  // Sources: 0 first timer, 1 second timer, 2 pins, 3 serial tx,
  // 4 serial rx, 5 outgoing mailbox, 6 incoming mailbox,
  // 7 fast serial block done, 8 fast serial rx full.
  function integer en_bit;
    input integer idx;
    begin
      if (idx == 0)
        en_bit = `CCDR_IE_TMR0;
      else if (idx == 1)
        en_bit = `CCDR_IE_TMR1;
      else if (idx == 2)
        en_bit = `CCDR_IE_GPIO;
      else if (idx == 3 || idx == 4)
        en_bit = `CCDR_IE_UART;
      else if (idx == 5)
        en_bit = `CCDR_IE_OUTGOING_MAILBOX_IRQ;
      else if (idx == 6)
        en_bit = `CCDR_IE_INCOMING_MAILBOX_IRQ;
      else
        en_bit = `CCDR_IE_FSS;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Write arbitration
  // --------------------------------------------------------------------------
  // The CPU wins a same-cycle write; the host write is dropped, which
  // software must avoid by using the mailbox protocol.
  wire wr_en;
  wire [15:0] wr_addr;
  wire [15:0] wr_data;
  assign wr_en = cpu_wr_i | host_wr_i;
  assign wr_addr = cpu_wr_i ? cpu_addr_i : host_addr_i;
  assign wr_data = cpu_wr_i ? cpu_wdata_i : host_wdata_i;

  wire wr_ie;
  wire wr_bkpt;
  wire wr_diag;
  wire wr_wdog;
  assign wr_ie = wr_en && (wr_addr == `CCDR_OFS_IRQ_EN);
  assign wr_bkpt = wr_en && (wr_addr == `CCDR_OFS_BKPT);
  assign wr_diag = wr_en && (wr_addr == `CCDR_OFS_DIAG);
  assign wr_wdog = wr_en && (wr_addr == `CCDR_OFS_WDOG);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg [15:0] interrupt_enable_mask;
  reg [15:0] breakpoint_address;
  reg [15:0] usb_line_diagnostic;
  reg [1:0] wd_period;
  reg wd_lock;
  reg wd_enable;
  reg wd_timeout;
  wire wd_expire;
  wire wd_restart;

  // Reserved bits are assumed written as zero; masking keeps them at their
  // reset values even if software slips.
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      interrupt_enable_mask <= `CCDR_RST_IRQ_EN;
      usb_line_diagnostic <= `CCDR_RST_DIAG;
    end else begin
      if (wr_ie)
        interrupt_enable_mask <= (wr_data & `CCDR_MSK_IRQ_EN) |
          `CCDR_RST_IRQ_EN; // [RULE_08]
      if (wr_diag)
        usb_line_diagnostic <= wr_data & `CCDR_MSK_DIAG; // [RULE_08]
    end
  end

  // --------------------------------------------------------------------------
  // Breakpoint
  // --------------------------------------------------------------------------
  // Address zero disarms the comparator, otherwise the clearing write
  // would re-raise the request at the reset vector.
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      breakpoint_address <= `CCDR_RST_BKPT;
      breakpoint_irq_o <= 1'b0;
    end else begin
      if (wr_bkpt)
        breakpoint_address <= wr_data;
      if (wr_bkpt && wr_data == 16'h0000)
        breakpoint_irq_o <= 1'b0; // [RULE_10]
      else if (breakpoint_address != 16'h0000 &&
               pc_i == breakpoint_address)
        breakpoint_irq_o <= 1'b1; // [RULE_09]
    end
  end

  // --------------------------------------------------------------------------
  // Pending flags and gating
  // --------------------------------------------------------------------------
  reg [NSRC-1:0] pending;
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_src
      localparam integer EB = en_bit(gi);
      wire wipe;
      if (EB == `CCDR_IE_TMR0 || EB == `CCDR_IE_TMR1 ||
          EB == `CCDR_IE_GPIO) begin : g_wipe
        assign wipe = wr_ie && !wr_data[EB]; // [RULE_05] [RULE_06] [RULE_07]
      end else begin : g_keep
        assign wipe = 1'b0;
      end
      always @(posedge core_clk_i) begin
        if (!rstn_i)
          pending[gi] <= 1'b0;
        else if (src_evt_i[gi])
          pending[gi] <= 1'b1;
        else if (wipe || src_ack_i[gi])
          pending[gi] <= 1'b0;
      end
      // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_23]
      assign cpu_irq_o[gi] = pending[gi] & interrupt_enable_mask[EB];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------------------
  // The restart strobe is honoured even when locked, since a locked
  // watchdog that could not be serviced would always fire.
  assign wd_restart = wr_wdog && wr_data[`CCDR_WD_STROBE]; // [RULE_22]

  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      wd_period <= 2'b00;
      wd_lock <= 1'b0;
      wd_enable <= 1'b0;
      wd_timeout <= 1'b0;
      watchdog_irq_o <= 1'b0;
      watchdog_cpu_reset_o <= 1'b0;
    end else begin
      watchdog_irq_o <= wd_expire; // [RULE_19]
      watchdog_cpu_reset_o <= wd_expire; // [RULE_20]
      if (wd_expire) begin
        wd_timeout <= 1'b1; // [RULE_18]
        wd_period <= 2'b00;
        wd_lock <= 1'b0;
        wd_enable <= 1'b0;
      end else if (wr_wdog && !wd_lock) begin // [RULE_21]
        wd_period <= wr_data[`CCDR_WD_PER_HI:`CCDR_WD_PER_LO];
        wd_lock <= wr_data[`CCDR_WD_LOCK];
        wd_enable <= wr_data[`CCDR_WD_EN];
      end
    end
  end

  reg [19:0] wd_limit;
  always @* begin
    case (wd_period) // [RULE_20]
      2'b00: wd_limit = WD_CYC0[19:0];
      2'b01: wd_limit = WD_CYC1[19:0];
      2'b10: wd_limit = WD_CYC2[19:0];
      default: wd_limit = WD_CYC3[19:0];
    endcase
  end

  ccdr_wdog #(
    .CW(20)
  ) u_wdog (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .run_i(wd_enable | wd_lock), // [RULE_21]
    .restart_i(wd_restart),
    .limit_i(wd_limit),
    .expire_o(wd_expire)
  );

  wire [15:0] wdog_word;
  assign wdog_word = {10'h000, wd_timeout, wd_period, wd_lock,
                      wd_enable, 1'b0};
  assign watchdog_status_o = wdog_word;

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  function [15:0] read_word;
    input [15:0] addr;
    input from_host;
    begin
      if (addr == `CCDR_OFS_IRQ_EN)
        read_word = interrupt_enable_mask;
      else if (addr == `CCDR_OFS_BKPT)
        read_word = breakpoint_address;
      else if (addr == `CCDR_OFS_DIAG)
        read_word = from_host ? 16'h0000 : usb_line_diagnostic; // [RULE_11]
      else if (addr == `CCDR_OFS_WDOG)
        read_word = wdog_word;
      else
        read_word = 16'h0000;
    end
  endfunction

  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      cpu_rdata_o <= 16'h0000;
      host_rdata_o <= 16'h0000;
    end else begin
      if (cpu_rd_i)
        cpu_rdata_o <= read_word(cpu_addr_i, 1'b0);
      if (host_rd_i)
        host_rdata_o <= read_word(host_addr_i, 1'b1);
    end
  end

  // --------------------------------------------------------------------------
  // Data-line diagnostics
  // --------------------------------------------------------------------------
  wire line_dp;
  wire line_dm;
  ccdr_line_diag #(
    .DIV(TOGGLE_DIV)
  ) u_line (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .sel_i(usb_line_diagnostic[`CCDR_DG_SEL_HI:`CCDR_DG_SEL_LO]),
    .dp_o(line_dp),
    .dm_o(line_dm)
  );

  wire p1_on;
  wire p2_on;
  wire pd_on;
  wire ls_on;
  wire fs_on;
  assign p1_on = usb_line_diagnostic[`CCDR_DG_P1_EN];
  assign p2_on = usb_line_diagnostic[`CCDR_DG_P2_EN];
  assign pd_on = usb_line_diagnostic[`CCDR_DG_PD];
  assign ls_on = usb_line_diagnostic[`CCDR_DG_LSPU];
  assign fs_on = usb_line_diagnostic[`CCDR_DG_FSPU];

  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      first_usb_port_dp_o <= 1'b0;
      first_usb_port_dm_o <= 1'b0;
      first_usb_port_oe_o <= 1'b0;
      first_usb_port_pd_o <= 1'b0;
      first_usb_port_lspu_o <= 1'b0;
      first_usb_port_fspu_o <= 1'b0;
      second_usb_port_dp_o <= 1'b0;
      second_usb_port_dm_o <= 1'b0;
      second_usb_port_oe_o <= 1'b0;
      second_usb_port_pd_o <= 1'b0;
      second_usb_port_lspu_o <= 1'b0;
      second_usb_port_fspu_o <= 1'b0;
    end else begin
      first_usb_port_dp_o <= p1_on & line_dp; // [RULE_13]
      first_usb_port_dm_o <= p1_on & line_dm;
      first_usb_port_oe_o <= p1_on;
      first_usb_port_pd_o <= p1_on & pd_on; // [RULE_14]
      first_usb_port_lspu_o <= p1_on & ls_on; // [RULE_15]
      first_usb_port_fspu_o <= p1_on & fs_on; // [RULE_16]
      second_usb_port_dp_o <= p2_on & line_dp; // [RULE_12]
      second_usb_port_dm_o <= p2_on & line_dm;
      second_usb_port_oe_o <= p2_on;
      second_usb_port_pd_o <= p2_on & pd_on; // [RULE_14]
      second_usb_port_lspu_o <= p2_on & ls_on; // [RULE_15]
      second_usb_port_fspu_o <= p2_on & fs_on; // [RULE_16]
    end
  end

endmodule // ccdr_top

// file: ccdr_consts.vh
// Purpose: Constants for the processor control and diagnostic register bank.
// Assumes: 10 MHz core clock, 16-bit byte addresses on both access ports.
// Notes: Definitions only, no logic.
//
// Overview of operation
// RULE_01 - Enable bit 7 gates fast serial block done and receive full.
// RULE_02 - Enable bit 6 gates the incoming mailbox interrupt to the CPU.
// RULE_03 - Enable bit 5 gates the outgoing mailbox interrupt to the CPU.
// RULE_04 - Enable bit 3 gates serial transmit and receive together.
// RULE_05 - Enable bit 2 gates pins; writing it zero drops pending ones.
// RULE_06 - Enable bit 1 gates second timer; writing zero wipes pending.
// RULE_07 - Enable bit 0 gates first timer; writing zero wipes pending.
// RULE_08 - Software writes zero into every reserved bit of this bank.
// RULE_09 - PC match with the breakpoint address raises its interrupt.
// RULE_10 - Writing zero to the breakpoint address drops its request.
// RULE_11 - Diagnostic register is CPU read/write, host port write-only.
// RULE_12 - Diagnostic bit 15 applies the test conditions to the second port.
// RULE_13 - Diagnostic bit 12 applies the test conditions to the first port.
// RULE_14 - Diagnostic bit 6 connects test pull-downs on both data lines.
// RULE_15 - Bit 5 connects the low-speed test pull-up on the minus line.
// RULE_16 - Bit 4 connects the full-speed test pull-up on the plus line.
// RULE_17 - Selector: 1xx SE0, 01x toggles J/K, 001 holds J, 000 holds K.
// RULE_18 - Timeout flag sets on expiry and clears only on hardware reset.
// RULE_19 - The watchdog can also raise an interrupt to the processor.
// RULE_20 - Codes 00..11 pick 1.4, 5.5, 22.0, 66.0 ms; expiry resets the CPU.
// RULE_21 - Lock set rejects further writes; the watchdog then always runs.
// RULE_22 - Writing one to the restart strobe reloads the watchdog count.
// RULE_23 - Each forwarded request is pending flag AND enable, every cycle.
`ifndef CCDR_CONSTS_VH
`define CCDR_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CCDR_OFS_WDOG 16'hC00C
`define CCDR_OFS_IRQ_EN 16'hC00E
`define CCDR_OFS_TMR0 16'hC010
`define CCDR_OFS_TMR1 16'hC012
`define CCDR_OFS_BKPT 16'hC014
`define CCDR_OFS_DIAG 16'hC03C

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define CCDR_RST_IRQ_EN 16'h0010
`define CCDR_MSK_IRQ_EN 16'h00EF
`define CCDR_RST_BKPT 16'h0000
`define CCDR_RST_DIAG 16'h0000
`define CCDR_MSK_DIAG 16'h9077
`define CCDR_RST_WDOG 16'h0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CCDR_IE_TMR0 0
`define CCDR_IE_TMR1 1
`define CCDR_IE_GPIO 2
`define CCDR_IE_UART 3
`define CCDR_IE_OUTGOING_MAILBOX_IRQ 5
`define CCDR_IE_INCOMING_MAILBOX_IRQ 6
`define CCDR_IE_FSS 7
`define CCDR_DG_P2_EN 15
`define CCDR_DG_P1_EN 12
`define CCDR_DG_PD 6
`define CCDR_DG_LSPU 5
`define CCDR_DG_FSPU 4
`define CCDR_DG_SEL_HI 2
`define CCDR_DG_SEL_LO 0
`define CCDR_WD_FLAG 5
`define CCDR_WD_PER_HI 4
`define CCDR_WD_PER_LO 3
`define CCDR_WD_LOCK 2
`define CCDR_WD_EN 1
`define CCDR_WD_STROBE 0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CCDR_CLK_NS 100
`define CCDR_WD_T0_US 1400
`define CCDR_WD_T1_US 5500
`define CCDR_WD_T2_US 22000
`define CCDR_WD_T3_US 66000
`define CCDR_WD_CYC(us) ((us) * 1000 / `CCDR_CLK_NS)
`define CCDR_TOGGLE_DIV 10

`endif

// file: ccdr_wdog.v
// Purpose: Watchdog cycle counter with restart and expiry pulse.
// Assumes: Limit is at least one cycle.
// Notes: Counter is held at zero while not running.
`timescale 1ns/100ps
module ccdr_wdog #(
  parameter CW = 20
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire run_i,
  input wire restart_i,
  input wire [CW-1:0] limit_i,
  output reg expire_o
);
  reg [CW-1:0] count;

  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      count <= {CW{1'b0}};
      expire_o <= 1'b0;
    end else if (!run_i || restart_i) begin
      count <= {CW{1'b0}}; // [RULE_22]
      expire_o <= 1'b0;
    end else if (count >= limit_i - {{(CW-1){1'b0}}, 1'b1}) begin
      count <= {CW{1'b0}};
      expire_o <= 1'b1; // [RULE_20]
    end else begin
      count <= count + {{(CW-1){1'b0}}, 1'b1};
      expire_o <= 1'b0;
    end
  end
endmodule // ccdr_wdog

// file: ccdr_line_diag.v
// Purpose: Data-line test state generator for the diagnostic register.
// Assumes: J is plus high, minus low, as on a full-speed line.
// Notes: Toggle phase advances on a divided enable pulse.
`timescale 1ns/100ps
module ccdr_line_diag #(
  parameter DIV = 10
) (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [2:0] sel_i,
  output reg dp_o,
  output reg dm_o
);
  reg [15:0] div_cnt;
  reg tick;
  reg phase;

  // The toggle runs far slower than the core so the lines can be observed.
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (div_cnt >= DIV - 1) begin
      div_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      phase <= 1'b0;
      dp_o <= 1'b0;
      dm_o <= 1'b0;
    end else begin
      if (tick)
        phase <= ~phase;
      if (sel_i[2]) begin
        dp_o <= 1'b0; // [RULE_17]
        dm_o <= 1'b0;
      end else if (sel_i[1]) begin
        dp_o <= phase; // [RULE_17]
        dm_o <= ~phase;
      end else if (sel_i[0]) begin
        dp_o <= 1'b1; // [RULE_17]
        dm_o <= 1'b0;
      end else begin
        dp_o <= 1'b0; // [RULE_17]
        dm_o <= 1'b1;
      end
    end
  end
endmodule // ccdr_line_diag

// file: ccdr_top_monitor.sv
// Purpose: Port checks for the control and diagnostic register bank.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every ccdr_top instance; sees its ports only.
`timescale 1ns/100ps
`include "ccdr_consts.vh"
module ccdr_top_monitor (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [15:0] cpu_addr_i,
  input wire cpu_wr_i,
  input wire [15:0] cpu_wdata_i,
  input wire [15:0] host_addr_i,
  input wire host_wr_i,
  input wire host_rd_i,
  input wire [15:0] host_rdata_o,
  input wire [8:0] src_evt_i,
  input wire [8:0] cpu_irq_o,
  input wire breakpoint_irq_o,
  input wire watchdog_irq_o,
  input wire watchdog_cpu_reset_o,
  input wire [15:0] watchdog_status_o,
  input wire first_usb_port_oe_o,
  input wire first_usb_port_dp_o,
  input wire first_usb_port_dm_o,
  input wire second_usb_port_oe_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_ie;
    cpu_wr_i && cpu_addr_i == `CCDR_OFS_IRQ_EN;
  endsequence
  sequence s_dg;
    cpu_wr_i && cpu_addr_i == `CCDR_OFS_DIAG;
  endsequence
  // A later write would move the line outputs, so the check needs a gap.
  sequence s_quiet;
    !cpu_wr_i && !host_wr_i;
  endsequence
  sequence s_expire;
    watchdog_irq_o && watchdog_cpu_reset_o;
  endsequence
  // Re-enabling after the clearing write shows whether the pending was wiped.
  a_wipe_tmr0:
    assert property (s_ie ##0 (!cpu_wdata_i[0] && !src_evt_i[0]) ##1
      !src_evt_i[0] ##1 (s_ie ##0 (cpu_wdata_i[0] && !src_evt_i[0]))
      |=> !cpu_irq_o[0]) else $error("first timer request kept");
  a_wipe_pin:
    assert property (s_ie ##0 (!cpu_wdata_i[2] && !src_evt_i[2]) ##1
      !src_evt_i[2] ##1 (s_ie ##0 (cpu_wdata_i[2] && !src_evt_i[2]))
      |=> !cpu_irq_o[2]) else $error("pin request kept");
  a_gate_serial:
    assert property (s_ie ##0 !cpu_wdata_i[3] |=> cpu_irq_o[4:3] == 2'b00)
      else $error("serial request passed while masked");
  a_gate_fast:
    assert property (s_ie ##0 !cpu_wdata_i[7] |=> cpu_irq_o[8:7] == 2'b00)
      else $error("fast serial request passed while masked");
  a_diag_first_off:
    assert property (s_dg ##0 !cpu_wdata_i[12] ##1 s_quiet |=>
      !first_usb_port_oe_o && !first_usb_port_dp_o && !first_usb_port_dm_o)
      else $error("first port driven while disabled");
  a_diag_second_on:
    assert property (s_dg ##0 cpu_wdata_i[15] ##1 s_quiet |=>
      second_usb_port_oe_o) else $error("second port not enabled");
  a_diag_se0:
    assert property (s_dg ##0 (cpu_wdata_i[12] && cpu_wdata_i[2]) ##1
      s_quiet |=> ##1 (first_usb_port_oe_o && !first_usb_port_dp_o &&
      !first_usb_port_dm_o)) else $error("single ended zero not forced");
  a_host_blind:
    assert property (host_rd_i && host_addr_i == `CCDR_OFS_DIAG |=>
      host_rdata_o == 16'h0000) else $error("host read saw diagnostic");
  a_bkpt_clear:
    assert property (cpu_wr_i && cpu_addr_i == `CCDR_OFS_BKPT &&
      cpu_wdata_i == 16'h0000 |=> !breakpoint_irq_o)
      else $error("breakpoint request not dropped");
  a_wd_expire:
    assert property (s_expire |=> !watchdog_irq_o && watchdog_status_o[5])
      else $error("watchdog expiry pulse or flag wrong");
  a_flag_sticky:
    assert property (watchdog_status_o[5] |=> watchdog_status_o[5])
      else $error("timeout flag cleared without reset");
endmodule // ccdr_top_monitor
bind ccdr_top ccdr_top_monitor u_ccdr_mon (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cpu_addr_i(cpu_addr_i),
  .cpu_wr_i(cpu_wr_i), .cpu_wdata_i(cpu_wdata_i),
  .host_addr_i(host_addr_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
  .host_rdata_o(host_rdata_o), .src_evt_i(src_evt_i),
  .cpu_irq_o(cpu_irq_o), .breakpoint_irq_o(breakpoint_irq_o),
  .watchdog_irq_o(watchdog_irq_o),
  .watchdog_cpu_reset_o(watchdog_cpu_reset_o),
  .watchdog_status_o(watchdog_status_o),
  .first_usb_port_oe_o(first_usb_port_oe_o),
  .first_usb_port_dp_o(first_usb_port_dp_o),
  .first_usb_port_dm_o(first_usb_port_dm_o),
  .second_usb_port_oe_o(second_usb_port_oe_o));

// file: ccdr_cpu_model.sv
// Purpose: Stand-in for the processor and its interrupt sources.
// Assumes: Requests from the bench arrive on the falling edge.
// Notes: The program counter runs freely so a breakpoint is reached.
`timescale 1ns/100ps
module ccdr_cpu_model (
  input wire core_clk_i,
  input wire rstn_i,
  input wire [8:0] fire_i,
  input wire [8:0] take_i,
  input wire pc_load_i,
  input wire [15:0] pc_start_i,
  output wire [8:0] src_evt_o,
  output wire [8:0] src_ack_o,
  output reg [15:0] pc_o
);
  assign src_evt_o = fire_i;
  assign src_ack_o = take_i;
  // A load models a branch; starting high keeps early code off low traps.
  always @(posedge core_clk_i) begin
    if (!rstn_i)
      pc_o <= 16'h8000;
    else if (pc_load_i)
      pc_o <= pc_start_i;
    else
      pc_o <= pc_o + 16'h0001;
  end
endmodule // ccdr_cpu_model

// file: test_ccdr_top.sv
// Purpose: Self-checking bench for the control and diagnostic bank.
// Assumes: Short watchdog and toggle counts through parameters.
// Notes: Inputs change on the falling edge of the clock only.
`timescale 1ns/100ps
`include "ccdr_consts.vh"
module test_ccdr_top;
  localparam int W0 = 20;
  localparam int TD = 2;
  // Enable bit of each source, four bits a source, source 0 lowest.
  localparam logic [35:0] EMAP = 36'h776533210;
  logic clk, rstn, cwr, crd, hwr, hrd, pcl, bk, wirq, wrst;
  logic [15:0] ca, cw, cr, ha, hw, hr, pcs, pc, wst;
  logic [8:0] fire, take, evt, ack, irq;
  wire [5:0] p1, p2;
  int error_cnt, n_compared, cyc, npulse;
  ccdr_top #(.WD_CYC0(W0), .WD_CYC1(2 * W0), .WD_CYC2(3 * W0),
    .WD_CYC3(4 * W0), .TOGGLE_DIV(TD), .NSRC(9)) DUT (
    .core_clk_i(clk), .rstn_i(rstn), .cpu_addr_i(ca), .cpu_wr_i(cwr),
    .cpu_rd_i(crd), .cpu_wdata_i(cw), .cpu_rdata_o(cr), .host_addr_i(ha),
    .host_wr_i(hwr), .host_rd_i(hrd), .host_wdata_i(hw),
    .host_rdata_o(hr), .src_evt_i(evt), .src_ack_i(ack), .cpu_irq_o(irq),
    .pc_i(pc), .breakpoint_irq_o(bk), .watchdog_irq_o(wirq),
    .watchdog_cpu_reset_o(wrst), .watchdog_status_o(wst),
    .first_usb_port_oe_o(p1[5]), .first_usb_port_pd_o(p1[4]),
    .first_usb_port_lspu_o(p1[3]), .first_usb_port_fspu_o(p1[2]),
    .first_usb_port_dp_o(p1[1]), .first_usb_port_dm_o(p1[0]),
    .second_usb_port_oe_o(p2[5]), .second_usb_port_pd_o(p2[4]),
    .second_usb_port_lspu_o(p2[3]), .second_usb_port_fspu_o(p2[2]),
    .second_usb_port_dp_o(p2[1]), .second_usb_port_dm_o(p2[0]));
  ccdr_cpu_model u_cpu (.core_clk_i(clk), .rstn_i(rstn), .fire_i(fire),
    .take_i(take), .pc_load_i(pcl), .pc_start_i(pcs), .src_evt_o(evt),
    .src_ack_o(ack), .pc_o(pc));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A hang is cut short well past the longest expected run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  always @(negedge clk) begin
    if (wirq === 1'b1)
      npulse++;
  end
  task automatic summarize();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Both ports see the address and data; only the strobed one acts.
  task automatic wr(input bit h, input logic [15:0] a, d);
    @(negedge clk);
    {hwr, cwr} <= {h, !h};
    {ha, ca, hw, cw} <= {a, a, d, d};
    @(negedge clk);
    {hwr, cwr} <= 2'b00;
  endtask
  task automatic rd(input bit h, input logic [15:0] a, exp);
    @(negedge clk);
    {hrd, crd} <= {h, !h};
    {ha, ca} <= {a, a};
    @(negedge clk);
    {hrd, crd} <= 2'b00;
    chk(h ? hr : cr, exp);
  endtask
  task automatic src(input logic [8:0] f, k);
    @(negedge clk);
    {fire, take} <= {f, k};
    @(negedge clk);
    {fire, take} <= 18'h00000;
  endtask
  task automatic t_rst();
    rd(0, `CCDR_OFS_IRQ_EN, 16'h0010);
    rd(1, `CCDR_OFS_BKPT, 16'h0000);
    rd(0, `CCDR_OFS_DIAG, 16'h0000);
    rd(0, `CCDR_OFS_WDOG, 16'h0000);
    rd(0, `CCDR_OFS_TMR0, 16'h0000);
    rd(1, 16'hC020, 16'h0000);
  endtask
  task automatic t_gate();
    int b;
    for (int i = 0; i < 9; i++) begin
      b = EMAP[i*4 +: 4];
      wr(0, `CCDR_OFS_IRQ_EN, 16'h0000);
      src(9'h001 << i, 9'h000);
      chk({7'h00, irq}, 16'h0000);
      wr(i % 2, `CCDR_OFS_IRQ_EN, 16'h0001 << b);
      chk({7'h00, irq}, 16'h0001 << i);
      src(9'h000, 9'h001 << i);
      chk({7'h00, irq}, 16'h0000);
    end
  endtask
  task automatic t_wipe();
    wr(0, `CCDR_OFS_IRQ_EN, 16'h00EF);
    src(9'h1FF, 9'h000);
    chk({7'h00, irq}, 16'h01FF);
    wr(0, `CCDR_OFS_IRQ_EN, 16'h00E8);
    wr(0, `CCDR_OFS_IRQ_EN, 16'h00EF);
    chk({7'h00, irq}, 16'h01F8);
    src(9'h000, 9'h1FF);
  endtask
  task automatic t_bkpt();
    wr(0, `CCDR_OFS_BKPT, 16'h0140);
    rd(1, `CCDR_OFS_BKPT, 16'h0140);
    chk({15'h0000, bk}, 16'h0000);
    @(negedge clk);
    {pcs, pcl} <= {16'h0130, 1'b1};
    @(negedge clk);
    pcl <= 1'b0;
    for (int n = 0; n < 40 && bk !== 1'b1; n++)
      @(negedge clk);
    chk({15'h0000, bk}, 16'h0001);
    wr(0, `CCDR_OFS_BKPT, 16'h0000);
    chk({15'h0000, bk}, 16'h0000);
  endtask
  task automatic t_diag();
    logic [1:0] jk, ejk;
    wr(1, `CCDR_OFS_DIAG, 16'h9077);
    rd(0, `CCDR_OFS_DIAG, 16'h9077);
    rd(1, `CCDR_OFS_DIAG, 16'h0000);
    for (int s = 0; s < 8; s++) begin
      wr(0, `CCDR_OFS_DIAG, 16'h1000 | (s << 4) | s);
      repeat (2) @(negedge clk);
      jk = 2'b00;
      ejk = s > 3 ? 2'b00 : s > 1 ? 2'b11 : s == 1 ? 2'b10 : 2'b01;
      if (s > 3)
        chk({14'h0000, p1[1:0]}, 16'h0000);
      repeat (4 * TD) begin
        @(negedge clk);
        jk = jk | {p1[1:0] === 2'b10, p1[1:0] === 2'b01};
      end
      chk({4'h0, p1[5:2], jk, p2}, {5'h01, s[2:0], ejk, 6'h00});
    end
    wr(0, `CCDR_OFS_DIAG, 16'h8001);
    repeat (2) @(negedge clk);
    chk({4'h0, p1, p2}, 16'h0022);
    wr(0, `CCDR_OFS_DIAG, 16'h0000);
  endtask
  task automatic t_wdog();
    int n, k;
    for (int p = 0; p < 4; p++) begin
      wr(0, `CCDR_OFS_WDOG, 16'h0002 | (p << 3));
      for (n = 0; n < 400 && wirq !== 1'b1; n++)
        @(negedge clk);
      chk({15'h0000, wrst}, 16'h0001);
      chk(16'(n), 16'(W0 * (p + 1) + 1));
      rd(0, `CCDR_OFS_WDOG, 16'h0020);
      chk(wst, 16'h0020);
    end
    k = npulse;
    wr(0, `CCDR_OFS_WDOG, 16'h0002);
    repeat (6) begin
      repeat (8) @(negedge clk);
      wr(1, `CCDR_OFS_WDOG, 16'h0003);
    end
    chk(16'(npulse - k), 16'h0000);
    repeat (3 * W0) @(negedge clk);
    chk(16'(npulse - k), 16'h0001);
    wr(0, `CCDR_OFS_WDOG, 16'h0006);
    wr(0, `CCDR_OFS_WDOG, 16'h0000);
    repeat (2 * W0) @(negedge clk);
    chk(16'(npulse - k), 16'h0002);
    rstn <= 1'b0;
    repeat (2) @(negedge clk);
    rstn <= 1'b1;
    rd(0, `CCDR_OFS_WDOG, 16'h0000);
    chk(wst, 16'h0000);
  endtask
  initial begin
    rstn = 1'b0;
    {cwr, crd, hwr, hrd, pcl} = 5'h00;
    {ca, cw, ha, hw, pcs, fire, take} = 98'h0;
    repeat (6) @(negedge clk);
    rstn <= 1'b1;
    t_rst();
    t_gate();
    t_wipe();
    t_bkpt();
    t_diag();
    t_wdog();
    summarize();
  end
endmodule // test_ccdr_top
